// [logic/uas_pkg.sv]
package uas_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ = 250_000_000;
  localparam int BAUD_HZ = 115_200;
  localparam int OVS = 16;
  // oversample tick divider, floor keeps the bit slightly fast
  localparam int SAMPLE_DIV = CLK_HZ / (BAUD_HZ * OVS);
  localparam logic [7:0] DIV_LAST = 8'(SAMPLE_DIV - 1);
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_HALF = 4'h7;

  ////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_STAT = 6'h01;
  localparam logic [5:0] IDX_DATA = 6'h02;
  localparam logic [5:0] IDX_S2 = 6'h05;

  // serial_status_two fields
  localparam int B_BRK = 7;
  localparam int B_EDGE = 6;
  localparam int B_RSV = 5;
  localparam int B_INV = 4;
  localparam int B_WAKE = 3;
  localparam int B_LONG = 2;
  localparam int B_RAISE = 1;
  localparam int B_RAF = 0;

  // control fields
  localparam int C_NINE = 0;
  localparam int C_TWO = 1;
  localparam int C_SEND = 2;
  localparam int C_STBY = 3;

  // status fields
  localparam int S_FULL = 0;
  localparam int S_FE = 1;
  localparam int S_IDLE = 2;
  localparam int S_NINTH = 3;
  localparam int S_TXBRK = 4;

  localparam logic [7:0] S2_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // frame lengths in bit times
  localparam logic [3:0] BASE_BITS = 4'ha;
  localparam logic [3:0] LONG_EXTRA = 4'h3;
  localparam logic [3:0] DATA8 = 4'h8;
  localparam logic [3:0] DATA9 = 4'h9;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } uas_rx_st_t;

  function automatic logic [3:0] uas_frame_bits(input logic nine,
                                                input logic two);
    return BASE_BITS + {3'h0, nine} + {3'h0, two};
  endfunction

endpackage

// [logic/uas_brk_if.sv]
`timescale 1ns/1ps
interface uas_brk_if;
  logic tick;
  logic line;
  logic [3:0] thr;
  logic hit;
  modport det(input tick, input line, input thr, output hit);
  modport ctl(output tick, output line, output thr, input hit);
endinterface

// [logic/uas_break_det.sv]
`timescale 1ns/1ps
module uas_break_det import uas_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link to the receiver
  uas_brk_if.det bif
);

  logic [3:0] ovs_r, ovs_nxt;
  logic [3:0] bits_r, bits_nxt;
  logic done_r, done_nxt;
  logic hit_r, hit_nxt;

  always_comb begin
    ovs_nxt = ovs_r;
    bits_nxt = bits_r;
    done_nxt = done_r;
    hit_nxt = 1'b0;
    if (bif.line) begin
      ovs_nxt = 4'h0;
      bits_nxt = 4'h0;
      done_nxt = 1'b0;
    end else if (bif.tick) begin
      ovs_nxt = ovs_r + 4'h1;
      if (ovs_r == OVS_LAST && bits_r != 4'hf) begin
        bits_nxt = bits_r + 4'h1;
        // one pulse per low stretch, however long it lasts
        if (bits_r + 4'h1 == bif.thr && !done_r) begin
          hit_nxt = 1'b1;
          done_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovs_r <= 4'h0;
      bits_r <= 4'h0;
      done_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      ovs_r <= ovs_nxt;
      bits_r <= bits_nxt;
      done_r <= done_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign bif.hit = hit_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [7:0] low_ticks_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || bif.line) begin
      low_ticks_r <= 8'h00;
    end else if (bif.tick && low_ticks_r != 8'hff) begin
      low_ticks_r <= low_ticks_r + 8'h01;
    end
  end

  brk_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(hit_r) |-> low_ticks_r == {bif.thr, 4'h0})
    else $error("break hit without threshold of low time");

  brk_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hit_r |=> !hit_r)
    else $error("break hit longer than one cycle");

endmodule

// [logic/uas_status_two.sv]
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module uas_status_two import uas_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial line
  input wire logic rx_pin_i,
  output logic tx_pin_o
);

  function automatic logic at_idx(input logic [5:0] a, input logic [5:0] i);
    return a == i;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin sync and oversample tick
  logic s1_r, s2_r, s3_r;
  logic [7:0] div_r, div_nxt;
  logic tick, line, line_prev, edge_act;
  logic inv_r, inv_nxt;

  always_comb begin
    div_nxt = tick ? 8'h00 : div_r + 8'h01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      div_r <= 8'h00;
    end else begin
      s1_r <= rx_pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      div_r <= div_nxt;
    end
  end

  assign tick = div_r == DIV_LAST;
  // every receive path, break and idle included, sees this line
  assign line = s2_r ^ inv_r;
  // both taps share one inversion, so toggling it makes no edge
  assign line_prev = s3_r ^ inv_r;
  assign edge_act = line_prev && !line;

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave, one wait state, write lands on the ack edge
  logic req, wr_en, ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [5:0] idx;
  logic w_s2, w_ctrl, w_stat;
  logic [7:0] s2_view, ctrl_view, stat_view;
  logic [7:0] data_r, data_nxt;
  logic tx_busy_r, tx_busy_nxt, tx_pend_r, tx_pend_nxt;

  assign req = wb_cyc_i && wb_stb_i;
  assign idx = wb_adr_i[7:2];
  assign wr_en = req && wb_we_i && ack_r && wb_sel_i[0];
  assign w_s2 = wr_en && at_idx(idx, IDX_S2);
  assign w_ctrl = wr_en && at_idx(idx, IDX_CTRL);
  assign w_stat = wr_en && at_idx(idx, IDX_STAT);

  always_comb begin
    ack_nxt = req && !ack_r;
    dat_nxt = dat_r;
    if (req && !ack_r) begin
      dat_nxt = 32'h0;
      if (at_idx(idx, IDX_S2)) dat_nxt[7:0] = s2_view;
      if (at_idx(idx, IDX_CTRL)) dat_nxt[7:0] = ctrl_view;
      if (at_idx(idx, IDX_STAT)) dat_nxt[7:0] = stat_view;
      if (at_idx(idx, IDX_DATA)) dat_nxt[7:0] = data_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////
  // registers and sticky flags
  logic wake_r, wake_nxt, long_r, long_nxt, raise_r, raise_nxt;
  logic brk_r, brk_nxt, edge_r, edge_nxt, raf_r, raf_nxt;
  logic nine_r, nine_nxt, two_r, two_nxt, stby_r, stby_nxt;
  logic full_r, full_nxt, fe_r, fe_nxt, idle_r, idle_nxt;
  logic ninth_r, ninth_nxt;
  logic start_ok, frame_done, stop_low, idle_evt, brk_hit;
  logic [8:0] shift_r, shift_nxt;

  // bit 5 is a hard zero in the read view
  assign s2_view = {brk_r, edge_r, 1'b0, inv_r, wake_r, long_r,
                    raise_r, raf_r};
  assign ctrl_view = {4'h0, stby_r, 1'b0, two_r, nine_r};
  assign stat_view = {3'h0, tx_busy_r, ninth_r, idle_r, fe_r, full_r};

  always_comb begin
    inv_nxt = inv_r;
    wake_nxt = wake_r;
    long_nxt = long_r;
    raise_nxt = raise_r;
    nine_nxt = nine_r;
    two_nxt = two_r;
    stby_nxt = stby_r;
    if (w_s2) begin
      inv_nxt = wb_dat_i[B_INV];
      wake_nxt = wb_dat_i[B_WAKE];
      long_nxt = wb_dat_i[B_LONG];
      raise_nxt = wb_dat_i[B_RAISE];
    end
    if (w_ctrl) begin
      nine_nxt = wb_dat_i[C_NINE];
      two_nxt = wb_dat_i[C_TWO];
      stby_nxt = wb_dat_i[C_STBY];
    end
    // clears first so a same-cycle event still sets
    brk_nxt = brk_r;
    if (w_s2 && wb_dat_i[B_BRK]) brk_nxt = 1'b0;
    if (brk_hit && raise_r) brk_nxt = 1'b1;
    edge_nxt = edge_r;
    if (w_s2 && wb_dat_i[B_EDGE]) edge_nxt = 1'b0;
    if (edge_act) edge_nxt = 1'b1;
    full_nxt = full_r;
    fe_nxt = fe_r;
    idle_nxt = idle_r;
    if (w_stat && wb_dat_i[S_FULL]) full_nxt = 1'b0;
    if (w_stat && wb_dat_i[S_FE]) fe_nxt = 1'b0;
    if (w_stat && wb_dat_i[S_IDLE]) idle_nxt = 1'b0;
    data_nxt = data_r;
    ninth_nxt = ninth_r;
    if (frame_done && !raise_r) begin
      full_nxt = 1'b1;
      fe_nxt = fe_nxt || stop_low;
      data_nxt = nine_r ? shift_r[7:0] : shift_r[8:1];
      ninth_nxt = nine_r ? shift_r[8] : 1'b0;
    end
    if (idle_evt && (!stby_r || wake_r)) idle_nxt = 1'b1;
    raf_nxt = raf_r;
    if (idle_evt) raf_nxt = 1'b0;
    if (start_ok) raf_nxt = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {brk_r, edge_r} <= S2_RST[7:6];
      {inv_r, wake_r, long_r, raise_r} <= S2_RST[4:1];
      raf_r <= S2_RST[B_RAF];
      {stby_r, two_r, nine_r} <= {CTRL_RST[C_STBY], CTRL_RST[C_TWO],
                                  CTRL_RST[C_NINE]};
      full_r <= 1'b0;
      fe_r <= 1'b0;
      idle_r <= 1'b0;
      ninth_r <= 1'b0;
      data_r <= 8'h00;
    end else begin
      {brk_r, edge_r, inv_r, wake_r, long_r, raise_r} <=
        {brk_nxt, edge_nxt, inv_nxt, wake_nxt, long_nxt, raise_nxt};
      raf_r <= raf_nxt;
      {stby_r, two_r, nine_r} <= {stby_nxt, two_nxt, nine_nxt};
      full_r <= full_nxt;
      fe_r <= fe_nxt;
      idle_r <= idle_nxt;
      ninth_r <= ninth_nxt;
      data_r <= data_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver
  uas_rx_st_t st_r, st_nxt;
  logic [3:0] ovs_r, ovs_nxt, bitn_r, bitn_nxt;
  logic [7:0] idle_cnt_r, idle_cnt_nxt, idle_last;
  logic arm_r, arm_nxt;

  // only the first stop is checked; the second is idle time
  assign idle_last = {uas_frame_bits(nine_r, two_r), 4'h0} - 8'h01;

  always_comb begin
    st_nxt = st_r;
    ovs_nxt = ovs_r;
    bitn_nxt = bitn_r;
    shift_nxt = shift_r;
    idle_cnt_nxt = 8'h00;
    arm_nxt = arm_r;
    start_ok = 1'b0;
    frame_done = 1'b0;
    stop_low = 1'b0;
    idle_evt = 1'b0;
    unique case (st_r)
      RX_IDLE: begin
        idle_cnt_nxt = idle_cnt_r;
        if (tick) begin
          if (!line) begin
            st_nxt = RX_START;
            ovs_nxt = 4'h0;
          end else if (idle_cnt_r == idle_last) begin
            idle_evt = arm_r;
            arm_nxt = 1'b0;
          end else begin
            idle_cnt_nxt = idle_cnt_r + 8'h01;
          end
        end
        if (!line) idle_cnt_nxt = 8'h00;
      end
      RX_START: begin
        if (tick) begin
          ovs_nxt = ovs_r + 4'h1;
          if (line) begin
            st_nxt = RX_IDLE;
          end else if (ovs_r == OVS_HALF) begin
            st_nxt = RX_DATA;
            ovs_nxt = 4'h0;
            bitn_nxt = 4'h0;
            start_ok = 1'b1;
            arm_nxt = 1'b1;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          ovs_nxt = ovs_r + 4'h1;
          if (ovs_r == OVS_LAST) begin
            shift_nxt = {line, shift_r[8:1]};
            bitn_nxt = bitn_r + 4'h1;
            if (bitn_r == (nine_r ? DATA9 : DATA8) - 4'h1) begin
              st_nxt = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          ovs_nxt = ovs_r + 4'h1;
          if (ovs_r == OVS_LAST) begin
            st_nxt = RX_IDLE;
            frame_done = 1'b1;
            stop_low = !line;
          end
        end
      end
      default: st_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= RX_IDLE;
      ovs_r <= 4'h0;
      bitn_r <= 4'h0;
      shift_r <= 9'h000;
      idle_cnt_r <= 8'h00;
      arm_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ovs_r <= ovs_nxt;
      bitn_r <= bitn_nxt;
      shift_r <= shift_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      arm_r <= arm_nxt;
    end
  end

  uas_brk_if brk_bus();
  assign brk_bus.tick = tick;
  assign brk_bus.line = line;
  assign brk_bus.thr = uas_frame_bits(nine_r, two_r)
                       + {3'h0, raise_r};
  assign brk_hit = brk_bus.hit;

  uas_break_det u_brk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bif(brk_bus.det)
  );

  ////////////////////////////////////////////////////////////////////////
  // break transmitter, starts on a tick so its length is exact
  logic [3:0] tx_ovs_r, tx_ovs_nxt, tx_bits_r, tx_bits_nxt;
  logic [3:0] tx_len, tx_len_r, tx_len_nxt;
  logic tx_pin_r;

  assign tx_len = uas_frame_bits(nine_r, two_r)
                  + (long_r ? LONG_EXTRA : 4'h0);

  always_comb begin
    tx_busy_nxt = tx_busy_r;
    tx_ovs_nxt = tx_ovs_r;
    tx_bits_nxt = tx_bits_r;
    tx_len_nxt = tx_len_r;
    tx_pend_nxt = tx_pend_r || (w_ctrl && wb_dat_i[C_SEND]);
    if (tick && !tx_busy_r && tx_pend_r) begin
      tx_busy_nxt = 1'b1;
      tx_pend_nxt = 1'b0;
      tx_ovs_nxt = 4'h0;
      tx_bits_nxt = 4'h0;
      tx_len_nxt = tx_len;
    end else if (tick && tx_busy_r) begin
      tx_ovs_nxt = tx_ovs_r + 4'h1;
      if (tx_ovs_r == OVS_LAST) begin
        tx_bits_nxt = tx_bits_r + 4'h1;
        if (tx_bits_r == tx_len_r - 4'h1) tx_busy_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_busy_r <= 1'b0;
      tx_pend_r <= 1'b0;
      tx_ovs_r <= 4'h0;
      tx_bits_r <= 4'h0;
      tx_len_r <= 4'h0;
      tx_pin_r <= 1'b1;
    end else begin
      tx_busy_r <= tx_busy_nxt;
      tx_pend_r <= tx_pend_nxt;
      tx_ovs_r <= tx_ovs_nxt;
      tx_bits_r <= tx_bits_nxt;
      tx_len_r <= tx_len_nxt;
      tx_pin_r <= !tx_busy_nxt;
    end
  end

  assign tx_pin_o = tx_pin_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [19:0] tx_low_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_pin_r) begin
      tx_low_r <= 20'h0;
    end else begin
      tx_low_r <= tx_low_r + 20'h1;
    end
  end

  tx_brk_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(tx_pin_r) |->
      $past(tx_low_r) + 20'h1 == 20'({tx_len_r, 4'h0}) * 20'(SAMPLE_DIV))
    else $error("transmitted break length wrong");

  brk_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    brk_hit && raise_r |=> brk_r)
    else $error("break flag not set");

  brk_flag_hold_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    brk_r && !(w_s2 && wb_dat_i[B_BRK]) |=> brk_r)
    else $error("break flag lost without write one");

  edge_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(s2_r ^ inv_r) && $stable(inv_r) |=> edge_r)
    else $error("edge flag missed active edge");

  rsv_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && at_idx(idx, IDX_S2) |-> !wb_dat_o[B_RSV])
    else $error("reserved bit read nonzero");

  fe_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(fe_r) || $rose(full_r)) |-> !$past(raise_r))
    else $error("flag set while threshold raised");

  idle_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    idle_evt && stby_r && !wake_r && !idle_r |=> !idle_r)
    else $error("idle flag set in quiet standby");

  idle_report_a: assert property (@(posedge clk_i) disable iff (rst_i)
    idle_evt && (!stby_r || wake_r) |=> idle_r)
    else $error("idle flag not set");

  raf_track_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_ok |=> raf_r ##1 (raf_r [*8]))
    else $error("receiver active not held after start");

endmodule

// [bench/uas_node.sv]
`timescale 1ns/1ps
module uas_node import uas_pkg::*; (
  // clock
  input wire logic clk_i,
  // serial lines seen from the remote node
  input wire logic tx_i,
  output logic rx_o
);
  localparam int BIT_CLKS = SAMPLE_DIV * OVS;
  int run = 0;
  int low_len = 0;

  initial begin
    rx_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // length in clocks of the last low stretch sent by the port
  always @(posedge clk_i) begin
    if (tx_i === 1'b0) begin
      run <= run + 1;
    end else if (run != 0) begin
      low_len <= run;
      run <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // caller sits just after a rising edge, so the line moves off the edge
  task automatic put(input logic lvl, input int clks);
    rx_o <= lvl;
    repeat (clks) @(posedge clk_i);
  endtask

  // start, eight data bits lsb first, one stop
  task automatic send_byte(input logic [7:0] d, input logic inv);
    put(inv, BIT_CLKS);
    for (int i = 0; i < 8; i++) begin
      put(d[i] ^ inv, BIT_CLKS);
    end
    put(~inv, BIT_CLKS);
  endtask

  // break symbol, then back to the idle level
  task automatic send_low(input int bits, input logic inv);
    put(inv, bits * BIT_CLKS);
    put(~inv, 1);
  endtask
endmodule

// [bench/uas_status_two_test.sv]
`timescale 1ns/1ps
module uas_status_two_test import uas_pkg::*;;
  localparam int BIT_CLKS = SAMPLE_DIV * OVS;
  localparam int LIMIT = 100000;
  localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] A_STAT = {IDX_STAT, 2'b00};
  localparam logic [7:0] A_DATA = {IDX_DATA, 2'b00};
  localparam logic [7:0] A_S2 = {IDX_S2, 2'b00};
  localparam logic [7:0] A_BAD = 8'h3c;
  localparam logic [31:0] ALL = 32'hffffffff;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic rx_line;
  logic tx_line;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  uas_status_two uas_status_two_inst (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .rx_pin_i(rx_line), .tx_pin_o(tx_line)
  );

  uas_node uas_node_inst (.clk_i(clk_i), .tx_i(tx_line), .rx_o(rx_line));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    check(r & m, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(A_S2, ALL, 32'h00);
    wr(A_S2, 8'hef);
    rd_chk(A_S2, ALL, 32'h0e);
    wr(A_S2, 8'h00);
    wr(A_BAD, 8'hff);
    rd_chk(A_BAD, ALL, 32'h00);
    // short pulses stay under the valid start time
    uas_node_inst.put(1'b0, 8);
    rd_chk(A_S2, ALL, 32'h40);
    wr(A_S2, 8'h00);
    rd_chk(A_S2, ALL, 32'h40);
    wr(A_S2, 8'h40);
    uas_node_inst.put(1'b1, 8);
    rd_chk(A_S2, ALL, 32'h00);
    uas_node_inst.put(1'b0, 2);
    wr(A_S2, 8'h10);
    wr(A_S2, 8'h50);
    rd_chk(A_S2, ALL, 32'h10);
    uas_node_inst.put(1'b1, 8);
    rd_chk(A_S2, ALL, 32'h50);
    wr(A_S2, 8'h50);
    uas_node_inst.put(1'b0, 8);
    rd_chk(A_S2, ALL, 32'h10);
    // inverted byte in, standby with wake report, short break out
    wr(A_S2, 8'h18);
    fork
      uas_node_inst.send_byte(8'ha5, 1'b1);
      begin
        wr(A_CTRL, 8'h0c);
        repeat (3 * BIT_CLKS) @(posedge clk_i);
        rd_chk(A_S2, ALL, 32'h59);
      end
    join
    rd_chk(A_DATA, 32'hff, 32'ha5);
    rd_chk(A_STAT, 32'h07, 32'h01);
    rd_chk(A_CTRL, ALL, 32'h08);
    repeat (11 * BIT_CLKS) @(posedge clk_i);
    rd_chk(A_S2, ALL, 32'h58);
    rd_chk(A_STAT, 32'h07, 32'h05);
    check(uas_node_inst.low_len, 10 * BIT_CLKS);
    wr(A_STAT, 8'h07);
    // nine bits, two stops, long break, raised threshold
    wr(A_CTRL, 8'h03);
    wr(A_S2, 8'h56);
    fork
      uas_node_inst.send_low(14, 1'b1);
      begin
        wr(A_CTRL, 8'h07);
        repeat (12 * BIT_CLKS + BIT_CLKS / 2) @(posedge clk_i);
        rd_chk(A_S2, 32'h80, 32'h00);
        repeat (BIT_CLKS) @(posedge clk_i);
        rd_chk(A_S2, 32'h80, 32'h80);
      end
    join
    rd_chk(A_STAT, 32'h03, 32'h00);
    wr(A_S2, 8'h16);
    rd_chk(A_S2, 32'h80, 32'h80);
    wr(A_S2, 8'h96);
    rd_chk(A_S2, 32'h80, 32'h00);
    repeat (2 * BIT_CLKS) @(posedge clk_i);
    check(uas_node_inst.low_len, 15 * BIT_CLKS);
    wrap_up();
  end
endmodule
